/* hdl/dual_wiper_i2c_target.sv */
// Two-wire serial target for a dual 256-position wiper
//
// Behaviour
// - Data falling while clock high starts transaction
// - Fixed variant answers only address 0101111
// - Configurable variant takes two low bits from straps
// - Matching address acknowledged; others idle until stop or start
// - Read/write bit one reads, zero writes
// - Instruction top bit selects wiper channel
// - Next bit shuts down, stored codes kept
// - Codes still stored in shutdown, reapplied after
// - Six low instruction bits are ignored
// - Data byte acknowledged while the FIFO has room, loads selected wiper register
// - Data line changes only while clock low
// - Read sends data right after address acknowledge
// - Read returns channel last selected by write
// - Instruction without data still updates selection
// - Data rising while clock high stops, idle
// - Every further written byte the FIFO has room for updates selected wiper
// - Acknowledged read bytes repeat the selected code
`timescale 1ns/1ps
`include "dual_wiper_map.svh"
module dual_wiper_i2c_target (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       addr_cfg_en_i,
    input  wire logic       addr_strap_pin_0_i,
    input  wire logic       addr_strap_pin_1_i,
    input  wire logic       wiper_hold_i,
    output logic [7:0]      wiper_register_0_o,
    output logic [7:0]      wiper_register_1_o,
    output logic            channel_select_bit_o,
    output logic            shutdown_bit_o,
    output logic            term_a_open_o,
    output logic            wiper_to_b_o
);
    import dual_wiper_pkg::*;

    core_t     r_ff;
    core_t     nxt_r;
    logic      scl_rise;
    logic      scl_fall;
    logic      start_det;
    logic      stop_det;
    logic      fifo_in_ready;
    logic      fifo_out_valid;
    logic      fifo_out_ready;
    wiper_wr_t fifo_out;
    logic      pop;
    logic [6:0] own_addr;
    logic [7:0] sel_code;

    function automatic logic [6:0] target_addr(input logic cfg, input logic a1, input logic a0);
        target_addr = cfg ? {`DW_ADDR_UPPER, a1, a0}
                          : {`DW_ADDR_UPPER, `DW_ADDR_FIXED_LOW};
    endfunction : target_addr

    function automatic logic [7:0] pick_code(input logic sel, input logic [7:0] c0,
                                             input logic [7:0] c1);
        pick_code = sel ? c1 : c0;
    endfunction : pick_code

    // Bus events from the synchronised pins
    assign scl_rise  = r_ff.sync2.scl && !r_ff.scl_q;
    assign scl_fall  = !r_ff.sync2.scl && r_ff.scl_q;
    assign start_det = r_ff.sync2.scl && r_ff.scl_q && r_ff.sda_q && !r_ff.sync2.sda;
    assign stop_det  = r_ff.sync2.scl && r_ff.scl_q && !r_ff.sda_q && r_ff.sync2.sda;

    assign own_addr = target_addr(r_ff.sync2.cfg, r_ff.sync2.a1, r_ff.sync2.a0);
    assign sel_code = pick_code(r_ff.sel, r_ff.wiper0, r_ff.wiper1);

    assign fifo_out_ready = !wiper_hold_i;
    assign pop            = fifo_out_valid && fifo_out_ready;

    wiper_fifo #(
        .WIDTH (`DW_FIFO_WIDTH),
        .DEPTH (`DW_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (r_ff.push),
        .in_data_i   (r_ff.push_data),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out),
        .out_ready_i (fifo_out_ready)
    );

    always_comb begin
        nxt_r          = r_ff;
        nxt_r.sync1    = '{scl: scl_i, sda: sda_i, a0: addr_strap_pin_0_i,
                           a1: addr_strap_pin_1_i, cfg: addr_cfg_en_i};
        nxt_r.sync2    = r_ff.sync1;
        nxt_r.scl_q    = r_ff.sync2.scl;
        nxt_r.sda_q    = r_ff.sync2.sda;
        nxt_r.push     = 1'b0;
        // Stored codes drain into the wipers, shutdown or not
        if (pop) begin
            if (fifo_out.ch) begin
                nxt_r.wiper1 = fifo_out.code;
            end else begin
                nxt_r.wiper0 = fifo_out.code;
            end
        end
        if (stop_det) begin
            nxt_r.state = ST_IDLE;
            nxt_r.drv   = 1'b0;
        end else if (start_det) begin
            nxt_r.state  = ST_ADDR;
            nxt_r.bitcnt = 4'h0;
            nxt_r.drv    = 1'b0;
        end else begin
            case (r_ff.state)
                ST_ADDR, ST_INSTR, ST_DATA: begin
                    if (scl_rise) begin
                        nxt_r.shreg  = {r_ff.shreg[6:0], r_ff.sync2.sda};
                        nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                    end else if (scl_fall && r_ff.bitcnt == `DW_BITS_PER_BYTE) begin
                        nxt_r.bitcnt = 4'h0;
                        if (r_ff.state == ST_ADDR) begin
                            if (r_ff.shreg[7:1] == own_addr) begin
                                nxt_r.state = ST_ACK;
                                nxt_r.kind  = ACK_ADDR;
                                nxt_r.rw    = r_ff.shreg[0];
                                nxt_r.drv   = 1'b1;
                            end else begin
                                nxt_r.state = ST_SKIP;
                            end
                        end else if (r_ff.state == ST_INSTR) begin
                            nxt_r.sel   = r_ff.shreg[`DW_INSTR_SEL_BIT];
                            nxt_r.sd    = r_ff.shreg[`DW_INSTR_SD_BIT];
                            nxt_r.state = ST_ACK;
                            nxt_r.kind  = ACK_INSTR;
                            nxt_r.drv   = 1'b1;
                        end else if (fifo_in_ready) begin
                            nxt_r.push      = 1'b1;
                            nxt_r.push_data = '{ch: r_ff.sel, code: r_ff.shreg};
                            nxt_r.state     = ST_ACK;
                            nxt_r.kind      = ACK_DATA;
                            nxt_r.drv       = 1'b1;
                        end else begin
                            // No room: leave the byte unacknowledged
                            nxt_r.state = ST_SKIP;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        nxt_r.bitcnt = 4'h0;
                        if (r_ff.kind == ACK_ADDR && r_ff.rw) begin
                            nxt_r.state = ST_TX;
                            nxt_r.shreg = sel_code;
                            nxt_r.drv   = !sel_code[7];
                        end else begin
                            nxt_r.drv   = 1'b0;
                            nxt_r.state = (r_ff.kind == ACK_ADDR) ? ST_INSTR : ST_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (r_ff.bitcnt == `DW_TX_LAST_BIT) begin
                            nxt_r.state = ST_MACK;
                            nxt_r.drv   = 1'b0;
                        end else begin
                            nxt_r.shreg  = {r_ff.shreg[6:0], 1'b0};
                            nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                            nxt_r.drv    = !r_ff.shreg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise && r_ff.sync2.sda) begin
                        nxt_r.state = ST_SKIP;
                    end else if (scl_fall) begin
                        nxt_r.state  = ST_TX;
                        nxt_r.bitcnt = 4'h0;
                        nxt_r.shreg  = sel_code;
                        nxt_r.drv    = !sel_code[7];
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    nxt_r.drv = 1'b0;
                end
                default: begin
                    nxt_r.state = ST_IDLE;
                    nxt_r.drv   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_ff        <= '0;
            r_ff.sync1  <= '{scl: 1'b1, sda: 1'b1, a0: 1'b0, a1: 1'b0, cfg: 1'b0};
            r_ff.sync2  <= '{scl: 1'b1, sda: 1'b1, a0: 1'b0, a1: 1'b0, cfg: 1'b0};
            r_ff.scl_q  <= 1'b1;
            r_ff.sda_q  <= 1'b1;
            r_ff.state  <= ST_IDLE;
            r_ff.kind   <= ACK_ADDR;
            r_ff.wiper0 <= `DW_WIPER_RESET;
            r_ff.wiper1 <= `DW_WIPER_RESET;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Open-drain data pin: only ever pulls low
    assign sda_o                = 1'b0;
    assign sda_oe_o             = r_ff.drv;
    assign wiper_register_0_o   = r_ff.wiper0;
    assign wiper_register_1_o   = r_ff.wiper1;
    assign channel_select_bit_o = r_ff.sel;
    assign shutdown_bit_o       = r_ff.sd;
    assign term_a_open_o        = r_ff.sd;
    assign wiper_to_b_o         = r_ff.sd;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic addr_end;
    assign addr_end = r_ff.state == ST_ADDR && scl_fall && !stop_det && !start_det
                      && r_ff.bitcnt == `DW_BITS_PER_BYTE;

    start_to_addr_a: assert property (start_det && !stop_det |=> r_ff.state == ST_ADDR)
        else $error("start not followed by address state");
    fixed_addr_a: assert property (addr_end && !r_ff.sync2.cfg && r_ff.shreg[7:1] == 7'h2f
        |=> r_ff.state == ST_ACK && sda_oe_o)
        else $error("fixed address not acknowledged");
    strap_addr_a: assert property (addr_end && r_ff.sync2.cfg
        && r_ff.shreg[7:1] == {5'h0b, r_ff.sync2.a1, r_ff.sync2.a0}
        |=> r_ff.state == ST_ACK && sda_oe_o)
        else $error("strap address not acknowledged");
    foreign_addr_a: assert property (addr_end && r_ff.shreg[7:1] != own_addr
        |=> r_ff.state == ST_SKIP && !sda_oe_o)
        else $error("foreign address acknowledged");
    instr_latch_a: assert property (r_ff.state == ST_INSTR && scl_fall && !stop_det
        && !start_det && r_ff.bitcnt == `DW_BITS_PER_BYTE
        |=> r_ff.sel == $past(r_ff.shreg[7]) && r_ff.sd == $past(r_ff.shreg[6]))
        else $error("instruction byte not latched");
    pop_load_a: assert property (pop && !fifo_out.ch
        |=> wiper_register_0_o == $past(fifo_out.code))
        else $error("drained code not loaded into wiper");
    read_first_a: assert property (r_ff.state == ST_ACK && r_ff.kind == ACK_ADDR && r_ff.rw
        && scl_fall && !stop_det && !start_det
        |=> r_ff.state == ST_TX && sda_oe_o == !$past(sel_code[7]))
        else $error("read byte not started after address");
    oe_steady_a: assert property ($changed(sda_oe_o)
        |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
        else $error("data line changed away from clock fall");
    stop_idle_a: assert property (stop_det ##1 1'b1 |-> r_ff.state == ST_IDLE && !sda_oe_o)
        else $error("stop did not return to idle");
    repeat_read_a: assert property (r_ff.state == ST_MACK && scl_fall && !stop_det
        && !start_det |=> r_ff.state == ST_TX && r_ff.bitcnt == 4'h0)
        else $error("acknowledged read not repeated");

    write_data_c: cover property (r_ff.push ##1 pop);
    read_byte_c: cover property (r_ff.state == ST_TX ##1 r_ff.state == ST_MACK);
    foreign_c: cover property (r_ff.state == ST_ADDR ##1 r_ff.state == ST_SKIP);
    shutdown_c: cover property ($rose(shutdown_bit_o));
    repeat_read_c: cover property (r_ff.state == ST_MACK ##1 r_ff.state == ST_TX);

    // End of a received byte in a given state
    function automatic logic byte_end(input dw_state_t st, input dw_state_t want,
                                      input logic fall, input logic [3:0] cnt);
        byte_end = st == want && fall && cnt == `DW_BITS_PER_BYTE;
    endfunction : byte_end

    logic instr_end;
    logic data_end;
    logic ack_fall;
    assign instr_end = byte_end(r_ff.state, ST_INSTR, scl_fall, r_ff.bitcnt)
                       && !stop_det && !start_det;
    assign data_end  = byte_end(r_ff.state, ST_DATA, scl_fall, r_ff.bitcnt)
                       && !stop_det && !start_det;
    assign ack_fall  = r_ff.state == ST_ACK && scl_fall && !stop_det && !start_det;

    // Framing and acknowledge
    start_clear_a: assert property (start_det |=> r_ff.bitcnt == 4'h0 && !sda_oe_o)
        else $error("start did not clear the byte");
    addr_rw_a: assert property (addr_end && r_ff.shreg[7:1] == own_addr
        |=> r_ff.rw == $past(r_ff.shreg[0]))
        else $error("read/write bit not latched");
    write_instr_a: assert property (ack_fall && r_ff.kind == ACK_ADDR && !r_ff.rw
        |=> r_ff.state == ST_INSTR && !sda_oe_o)
        else $error("write did not move to instruction");
    ack_hold_a: assert property (r_ff.state == ST_ACK && !scl_fall
        && !stop_det && !start_det |=> sda_oe_o)
        else $error("acknowledge dropped early");
    ack_release_a: assert property (ack_fall && !(r_ff.kind == ACK_ADDR && r_ff.rw)
        |=> !sda_oe_o)
        else $error("acknowledge not released after ninth clock");
    quiet_bus_a: assert property (r_ff.state == ST_IDLE || r_ff.state == ST_SKIP
        |-> !sda_oe_o)
        else $error("data line pulled while not addressed");
    bitcnt_bound_a: assert property (r_ff.bitcnt <= `DW_BITS_PER_BYTE)
        else $error("bit count past one byte");

    // Instruction and write path
    instr_ack_a: assert property (instr_end
        |=> r_ff.state == ST_ACK && r_ff.kind == ACK_INSTR && sda_oe_o)
        else $error("instruction byte not acknowledged");
    sel_hold_a: assert property (!instr_end
        |=> $stable(channel_select_bit_o) && $stable(shutdown_bit_o))
        else $error("selection changed outside an instruction");
    data_push_a: assert property (data_end && fifo_in_ready
        |=> r_ff.push && sda_oe_o && r_ff.push_data.ch == $past(r_ff.sel)
            && r_ff.push_data.code == $past(r_ff.shreg))
        else $error("data byte not queued for the selected wiper");
    full_nack_a: assert property (data_end && !fifo_in_ready
        |=> r_ff.state == ST_SKIP && !sda_oe_o)
        else $error("data byte acknowledged with no room");
    push_in_ack_a: assert property (r_ff.push
        |-> r_ff.state == ST_ACK && r_ff.kind == ACK_DATA)
        else $error("push outside a data acknowledge");

    // Wiper storage
    pop_load1_a: assert property (pop && fifo_out.ch
        |=> wiper_register_1_o == $past(fifo_out.code))
        else $error("drained code not loaded into second wiper");
    sd_store_a: assert property (pop && shutdown_bit_o
        |=> $past(fifo_out.code)
            == ($past(fifo_out.ch) ? wiper_register_1_o : wiper_register_0_o))
        else $error("code not stored during shutdown");
    wiper_keep_a: assert property (!pop
        |=> $stable(wiper_register_0_o) && $stable(wiper_register_1_o))
        else $error("wiper code changed without a write");

    // Read path
    tx_shift_a: assert property (r_ff.state == ST_TX && scl_fall && !stop_det
        && !start_det && r_ff.bitcnt != `DW_TX_LAST_BIT |=> sda_oe_o == !$past(r_ff.shreg[6]))
        else $error("read bit not shifted out");
    tx_last_a: assert property (r_ff.state == ST_TX && scl_fall && !stop_det
        && !start_det && r_ff.bitcnt == `DW_TX_LAST_BIT
        |=> r_ff.state == ST_MACK && !sda_oe_o)
        else $error("data line not released for the acknowledge");
    read_nack_a: assert property (r_ff.state == ST_MACK && scl_rise && r_ff.sync2.sda
        |=> r_ff.state == ST_SKIP && !sda_oe_o)
        else $error("not-acknowledge did not end the read");
    read_code_a: assert property (r_ff.state == ST_MACK && scl_fall && !stop_det
        && !start_det |=> r_ff.shreg == $past(sel_code))
        else $error("repeated read not loaded from selected wiper");
endmodule : dual_wiper_i2c_target

/* pkg/dual_wiper_map.svh */
// Offsets, field positions, reset values and counts of the dual wiper target
`ifndef DUAL_WIPER_MAP_SVH
`define DUAL_WIPER_MAP_SVH

`define DW_ADDR_UPPER      5'h0b
`define DW_ADDR_FIXED_LOW  2'h3
`define DW_WIPER_RESET     8'h80
`define DW_BITS_PER_BYTE   4'h8
`define DW_TX_LAST_BIT     4'h7
`define DW_INSTR_SEL_BIT   7
`define DW_INSTR_SD_BIT    6
`define DW_FIFO_DEPTH      4
`define DW_FIFO_WIDTH      9

`endif

/* pkg/dual_wiper_pkg.sv */
// Types shared by the dual wiper target
package dual_wiper_pkg;
    `include "dual_wiper_map.svh"

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ADDR  = 8'h02,
        ST_INSTR = 8'h04,
        ST_DATA  = 8'h08,
        ST_ACK   = 8'h10,
        ST_TX    = 8'h20,
        ST_MACK  = 8'h40,
        ST_SKIP  = 8'h80
    } dw_state_t;

    typedef enum logic [1:0] {
        ACK_ADDR  = 2'h0,
        ACK_INSTR = 2'h1,
        ACK_DATA  = 2'h2
    } ack_kind_t;

    typedef struct packed {
        logic       ch;
        logic [7:0] code;
    } wiper_wr_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic a0;
        logic a1;
        logic cfg;
    } pin_t;

    typedef struct packed {
        pin_t       sync1;
        pin_t       sync2;
        logic       scl_q;
        logic       sda_q;
        dw_state_t  state;
        ack_kind_t  kind;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic       rw;
        logic       sel;
        logic       sd;
        logic       drv;
        logic       push;
        wiper_wr_t  push_data;
        logic [7:0] wiper0;
        logic [7:0] wiper1;
    } core_t;
endpackage : dual_wiper_pkg

/* hdl/wiper_fifo.sv */
// Small FIFO between the serial receiver and the wiper registers
`timescale 1ns/1ps
module wiper_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    import dual_wiper_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } fifo_st_t;

    fifo_st_t st_ff;
    fifo_st_t nxt_st;
    logic     push;
    logic     pop;

    assign in_ready_o  = st_ff.count != (AW+1)'(DEPTH);
    assign out_valid_o = st_ff.count != '0;
    assign out_data_o  = st_ff.mem[st_ff.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : ptr_inc

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_data_i;
            nxt_st.wr_ptr            = ptr_inc(st_ff.wr_ptr);
        end
        if (pop) begin
            nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
        end
        nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    count_bound_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_ff.count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
    full_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !in_ready_o && !out_ready_i |=> $stable(st_ff.count))
        else $error("full fifo changed count without drain");
endmodule : wiper_fifo

/* tb/i2c_ctrl_model.sv */
// Bus controller model: drives serial clock and open-drain data line
`timescale 1ns/1ps
module i2c_ctrl_model (
    input  wire logic       clk_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_low_o,
    output logic [8:0]      res_o,
    output logic            res_tgl_o
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
        res_o     = 9'h000;
        res_tgl_o = 1'b0;
    end

    // Wait clock cycles, then step just past the edge
    task automatic hc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : hc

    // Data falls while clock high
    task automatic start();
        hc(5);
        sda_low_o = 1'b1;
        hc(5);
        scl_o = 1'b0;
        hc(5);
    endtask : start

    // One bit: data set in clock low, sampled mid clock high
    task automatic bit_x(input logic b, output logic r);
        sda_low_o = ~b;
        hc(5);
        scl_o = 1'b1;
        hc(5);
        r = sda_i;
        hc(5);
        scl_o = 1'b0;
        hc(5);
    endtask : bit_x

    // Eight bits plus ninth bit; nb high releases the line
    task automatic xfer(input logic [7:0] d, input logic nb);
        logic [7:0] q;
        logic       a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(nb, a);
        res_o     = {~a, q};
        res_tgl_o = ~res_tgl_o;
    endtask : xfer

    // Data pulled low in clock low, released while clock high
    task automatic stop();
        sda_low_o = 1'b1;
        hc(5);
        scl_o = 1'b1;
        hc(5);
        sda_low_o = 1'b0;
        hc(10);
    endtask : stop
endmodule : i2c_ctrl_model

/* tb/dual_wiper_i2c_target_tb.sv */
// Self-checking bench of the dual wiper target
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module dual_wiper_i2c_target_tb;
    import dual_wiper_pkg::*;
    localparam logic [6:0] FIX_ADDR = 7'b0101111;
    logic       clk, nrst, scl, sda_low, sda, sda_o, sda_oe;
    logic       cfg_en, strap0, strap1, hold, sel, sd, a_open, w_b, res_tgl;
    logic [7:0] w0, w1, c0, c1, d, v;
    logic [8:0] res, exp_v;
    logic [8:0] exp_q[$];
    int         error_cnt, n_checks, cyc;

    assign sda = ~(sda_low | (sda_oe & ~sda_o));

    dual_wiper_i2c_target i_dut (.clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_cfg_en_i(cfg_en),
        .addr_strap_pin_0_i(strap0), .addr_strap_pin_1_i(strap1), .wiper_hold_i(hold),
        .wiper_register_0_o(w0), .wiper_register_1_o(w1), .channel_select_bit_o(sel),
        .shutdown_bit_o(sd), .term_a_open_o(a_open), .wiper_to_b_o(w_b));
    i2c_ctrl_model i_ctrl (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low),
        .res_o(res), .res_tgl_o(res_tgl));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Each finished byte is compared with the oldest note
    always @(res_tgl) begin
        if ($time > 0) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            `CHK(res, exp_v)
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("[ERR] %0t run did not finish", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic xb(input logic [7:0] b, input logic nb, input logic ea, input logic [7:0] ed);
        exp_q.push_back({ea, ed});
        i_ctrl.xfer(b, nb);
    endtask : xb

    // Start, address with write, instruction
    task automatic wr(input logic [6:0] a, input logic [7:0] ins, input logic ea);
        i_ctrl.start();
        xb({a, 1'b0}, 1'b1, ea, {a, 1'b0});
        xb(ins, 1'b1, ea, ins);
    endtask : wr

    // Read once with acknowledge, once with not-acknowledge, then stop
    task automatic rd(input logic [7:0] code);
        i_ctrl.start();
        xb({FIX_ADDR, 1'b1}, 1'b1, 1'b1, {FIX_ADDR, 1'b1});
        xb(8'hff, 1'b0, 1'b1, code);
        xb(8'hff, 1'b1, 1'b0, code);
        i_ctrl.stop();
    endtask : rd

    task automatic state(input logic [7:0] e0, input logic [7:0] e1, input logic es,
                         input logic ed);
        `CHK(w0, e0)
        `CHK(w1, e1)
        `CHK(sel, es)
        `CHK({sd, a_open, w_b}, {3{ed}})
    endtask : state

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    initial begin
        nrst   = 1'b0;
        cfg_en = 1'b0;
        strap0 = 1'b0;
        strap1 = 1'b0;
        hold   = 1'b0;
        void'($urandom(32'h45ff));
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        state(8'h80, 8'h80, 1'b0, 1'b0);
        `CHK(sda_oe, 1'b0)
        done("reset");
        c0 = $urandom;
        d  = $urandom;
        v  = $urandom;
        wr(FIX_ADDR, {2'b00, d[5:0]}, 1'b1);
        xb(v, 1'b1, 1'b1, v);
        xb(c0, 1'b1, 1'b1, c0);
        i_ctrl.stop();
        state(c0, 8'h80, 1'b0, 1'b0);
        done("write_repeat");
        c1 = $urandom;
        wr(FIX_ADDR, {2'b11, d[5:0]}, 1'b1);
        xb(c1, 1'b1, 1'b1, c1);
        i_ctrl.stop();
        state(c0, c1, 1'b1, 1'b1);
        wr(FIX_ADDR, {2'b10, ~d[5:0]}, 1'b1);
        i_ctrl.stop();
        state(c0, c1, 1'b1, 1'b0);
        done("shutdown");
        rd(c1);
        wr(FIX_ADDR, 8'h00, 1'b1);
        i_ctrl.stop();
        rd(c0);
        state(c0, c1, 1'b0, 1'b0);
        done("read");
        wr(7'h2e, 8'hc0, 1'b0);
        xb(8'h5a, 1'b1, 1'b0, 8'h5a);
        i_ctrl.stop();
        state(c0, c1, 1'b0, 1'b0);
        done("foreign");
        cfg_en = 1'b1;
        for (int k = 0; k < 4; k++) begin
            {strap1, strap0} = k[1:0];
            v = $urandom;
            repeat (4) @(posedge clk);
            #1;
            wr({5'b01011, k[1:0]}, 8'h80, 1'b1);
            xb(v, 1'b1, 1'b1, v);
            i_ctrl.stop();
            if (k != 3) begin
                wr(FIX_ADDR, 8'h00, 1'b0);
                i_ctrl.stop();
            end
            state(c0, v, 1'b1, 1'b0);
        end
        {cfg_en, strap1, strap0} = 3'b000;
        repeat (4) @(posedge clk);
        #1;
        done("straps");
        hold = 1'b1;
        wr(FIX_ADDR, 8'h00, 1'b1);
        for (int i = 0; i < 4; i++) begin
            xb(8'h10 + i[7:0], 1'b1, 1'b1, 8'h10 + i[7:0]);
        end
        xb(8'hee, 1'b1, 1'b0, 8'hee);
        i_ctrl.stop();
        state(c0, v, 1'b0, 1'b0);
        hold = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        state(8'h13, v, 1'b0, 1'b0);
        `CHK(exp_q.size(), 0)
        done("fifo");
        final_report();
    end
endmodule : dual_wiper_i2c_target_tb
